// ===== kil_pkg.sv
// Package for the keypad interrupt latch: register map, fields, reset values, types
`default_nettype none

package kil_pkg;
  // Register byte offsets
  localparam logic [3:0] KIL_OFS_ENABLE = 4'h0;  // keypad_pin_enable
  localparam logic [3:0] KIL_OFS_ISC    = 4'h4;  // interrupt_status_control
  localparam logic [3:0] KIL_OFS_PDATA  = 4'h8;  // shared port data
  localparam logic [3:0] KIL_OFS_PDIR   = 4'hc;  // shared_port_direction
  // Status/control field positions
  localparam int KIL_ISC_PEND = 0;               // keypad_pending_flag (RO)
  localparam int KIL_ISC_MASK = 1;               // keypad_mask_bit (RW)
  localparam int KIL_ISC_ACK  = 2;               // keypad_acknowledge_bit (W1, reads 0)
  // Reset values
  localparam logic [7:0] KIL_ENABLE_RST = 8'h00;
  localparam logic       KIL_MASK_RST   = 1'b0;
  localparam logic [7:0] KIL_PDATA_RST  = 8'h00;
  localparam logic [7:0] KIL_PDIR_RST   = 8'h00;
  // Handler vector addresses
  localparam logic [15:0] KIL_VEC_HI = 16'hffd2;
  localparam logic [15:0] KIL_VEC_LO = 16'hffd3;
  // AXI responses
  localparam logic [1:0] KIL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] KIL_RESP_SLVERR = 2'h2;

  // Pin drive bundle toward the pads
  typedef struct packed {
    logic [7:0] out;   // Output level
    logic [7:0] oe;    // Output enable
    logic [7:0] pull;  // Pull-up enable
  } kil_pad_t;
endpackage

`default_nettype wire

// ===== kil_detect.sv
// Keypad sample, synchroniser and request latch
`default_nettype none

module kil_detect #(
  parameter int N = 8  // Number of keypad inputs
) (
  input  wire logic         aclk,     // Bus clock
  input  wire logic         aresetn,  // Sync reset, active low
  input  wire logic [N-1:0] pins,     // Raw pad levels
  input  wire logic [N-1:0] enable,   // Keypad enable per pin
  input  wire logic         ack,      // Acknowledge pulse
  output logic     [N-1:0] pins_s,   // Synchronised levels
  output logic              pending   // Latched request
);
  // Refuse input counts the reduction logic is not meant for
  if (N < 1 || N > 32) begin : g_bad_n
    $error("kil_detect: N out of range");
  end

  logic [N-1:0] meta_q;      // First stage only
  logic [N-1:0] sync_q;      // Second stage
  logic         any_low;     // Some enabled pin low
  logic         all_hi_q;    // All enabled were high last cycle
  logic         pend_q;      // Request latch
  logic         ack_seen_q;  // Acknowledge awaiting release

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  assign any_low = |(enable & ~sync_q);
  assign pins_s  = sync_q;

  // Remember idle-high state for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) all_hi_q <= 1'b1;
    else          all_hi_q <= ~any_low;
  end

  // Acknowledge remembered until inputs release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_seen_q <= 1'b0;
    end else if (ack && any_low) begin
      ack_seen_q <= 1'b1;
    end else if (!any_low || !pend_q) begin
      ack_seen_q <= 1'b0;
    end
  end

  // Request latch; a new edge wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 1'b0;
    // fall after all high; unaffected by ack
    end else if (all_hi_q && any_low) begin
      pend_q <= 1'b1;
    end else if ((ack || ack_seen_q) && !any_low) begin
      pend_q <= 1'b0;
    end
  end

  assign pending = pend_q;
endmodule

`default_nettype wire

// ===== kil_top.sv
// Keypad interrupt latch top: AXI4-Lite registers, shared port, CPU interrupt
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`default_nettype none

module kil_top (
  input  wire logic        aclk,          // Bus clock, 250 MHz
  input  wire logic        aresetn,       // Sync reset, active low
  // AXI4-Lite write address
  input  wire logic [3:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  // AXI4-Lite write data
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Byte strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  // AXI4-Lite write response
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Response valid
  input  wire logic        s_bready,      // Response ready
  // AXI4-Lite read
  input  wire logic [3:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read valid
  input  wire logic        s_rready,      // Read ready
  // Shared port pins
  input  wire logic [7:0]  port_in,       // Pad input levels
  output kil_pkg::kil_pad_t port_pad,     // Pad drive, enable, pull-up
  // CPU side
  input  wire logic        vec_fetch,     // CPU fetch strobe
  input  wire logic [15:0] vec_addr,      // CPU fetch address
  output logic             cpu_irq,       // Unmasked request, level
  output logic             wake,          // Wake from wait, level
  output logic             irq            // Status interrupt, level
);
  localparam int N = 8;  // Keypad input count

  // Registers
  logic [N-1:0]      enable_q;    // keypad_pin_enable
  logic              mask_q;      // keypad_mask_bit
  logic [N-1:0]      pdata_q;     // Port data latch
  logic [N-1:0]      pdir_q;      // shared_port_direction
  logic              ack_q;       // Acknowledge pulse
  logic [N-1:0]      pins_s;      // Synchronised pins
  logic              pending;     // Latched request
  logic              pend_dly_q;  // For rising detect
  logic [0:0]        stat_q;      // Sticky event status
  logic [0:0]        imask_q;     // Event mask

  // Write channel holding
  logic              aw_have_q;   // Address held
  logic              w_have_q;    // Data held
  logic [3:0]        aw_q;        // Held address
  logic [31:0]       wd_q;        // Held data
  logic [3:0]        ws_q;        // Held strobes
  logic              do_wr;       // Perform write
  logic              vec_hit;     // Vector fetch acknowledge

  localparam logic [3:0] OFS_STAT = kil_pkg::KIL_OFS_ENABLE;  // Event status rides in bit 8
  localparam logic [3:0] OFS_IMSK = kil_pkg::KIL_OFS_ISC;     // Event mask rides in bit 8

  // Byte lane 0 write enable
  function automatic logic lane0(input logic [3:0] s);
    return s[0];
  endfunction

  assign do_wr = aw_have_q && w_have_q && !s_bvalid;

  // Address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_q      <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_have_q <= 1'b1;
      aw_q      <= s_awaddr;
    end else if (do_wr) begin
      aw_have_q <= 1'b0;
    end
  end

  // Data acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wd_q     <= '0;
      ws_q     <= '0;
    end else if (s_wvalid && s_wready) begin
      w_have_q <= 1'b1;
      wd_q     <= s_wdata;
      ws_q     <= s_wstrb;
    end else if (do_wr) begin
      w_have_q <= 1'b0;
    end
  end

  // Ready while the slot is empty and no write response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
    end else begin
      s_awready <= !aw_have_q && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready  <= !w_have_q && !(s_wvalid && s_wready) && !s_bvalid;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= kil_pkg::KIL_RESP_OKAY;
    end else if (do_wr) begin
      s_bvalid <= 1'b1;
      s_bresp  <= (aw_q[3:2] == 2'h0 || aw_q[3:2] == 2'h1 || aw_q[3:2] == 2'h2 ||
                   aw_q[3:2] == 2'h3) ? kil_pkg::KIL_RESP_OKAY : kil_pkg::KIL_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Register writes, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= kil_pkg::KIL_ENABLE_RST;
      mask_q   <= kil_pkg::KIL_MASK_RST;
      pdata_q  <= kil_pkg::KIL_PDATA_RST;
      pdir_q   <= kil_pkg::KIL_PDIR_RST;
    end else if (do_wr && lane0(ws_q)) begin
      case (aw_q)
        kil_pkg::KIL_OFS_ENABLE: enable_q <= wd_q[N-1:0];
        kil_pkg::KIL_OFS_ISC:    mask_q   <= wd_q[kil_pkg::KIL_ISC_MASK];
        kil_pkg::KIL_OFS_PDATA:  pdata_q  <= wd_q[N-1:0];
        kil_pkg::KIL_OFS_PDIR:   pdir_q   <= wd_q[N-1:0];
        default: ;
      endcase
    end
  end

  // Acknowledge pulse from bus write or vector fetch
  assign vec_hit = vec_fetch && (vec_addr == kil_pkg::KIL_VEC_HI ||
                                 vec_addr == kil_pkg::KIL_VEC_LO);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= vec_hit || (do_wr && lane0(ws_q) && aw_q == kil_pkg::KIL_OFS_ISC &&
               wd_q[kil_pkg::KIL_ISC_ACK]);
    end
  end

  kil_detect #(.N(N)) u_detect (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    (port_in),
    .enable  (enable_q),
    .ack     (ack_q),
    .pins_s  (pins_s),
    .pending (pending)
  );

  // Pad drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_pad <= '0;
    end else begin
      port_pad.out  <= pdata_q;
      port_pad.oe   <= pdir_q & ~enable_q;
      port_pad.pull <= enable_q;
    end
  end

  // CPU interrupt and wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_irq <= 1'b0;
      wake    <= 1'b0;
    end else begin
      cpu_irq <= pending && !mask_q;
      wake    <= pending && !mask_q;
    end
  end

  // Sticky event status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_dly_q <= 1'b0;
      stat_q     <= '0;
      imask_q    <= '0;
    end else begin
      pend_dly_q <= pending;
      if (do_wr && lane0(ws_q) && aw_q == OFS_IMSK && ws_q[1]) imask_q <= wd_q[8];
      stat_q <= (stat_q & ~((do_wr && lane0(ws_q) && aw_q == OFS_STAT && ws_q[1])
                ? wd_q[8] : 1'b0)) | (pending && !pend_dly_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= |(stat_q & imask_q);
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= kil_pkg::KIL_RESP_OKAY;
    end else if (s_rvalid) begin
      s_arready <= 1'b0;
      if (s_rready) s_rvalid <= 1'b0;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rresp   <= kil_pkg::KIL_RESP_OKAY;
      s_rdata   <= '0;
      case (s_araddr)
        kil_pkg::KIL_OFS_ENABLE: s_rdata <= {16'h0000, 7'h00, stat_q, 8'h00 | enable_q};
        kil_pkg::KIL_OFS_ISC:    s_rdata <= {16'h0000, 7'h00, imask_q, 5'h00, 1'b0,
                                             mask_q, pending}; // pending flag
        // pin read only with direction zero
        kil_pkg::KIL_OFS_PDATA:  s_rdata <= {24'h000000, (pins_s & ~pdir_q) |
                                             (pdata_q & pdir_q)};
        kil_pkg::KIL_OFS_PDIR:   s_rdata <= {24'h000000, pdir_q};
        default:                 s_rresp <= kil_pkg::KIL_RESP_SLVERR;
      endcase
    end else begin
      s_arready <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ===== kil_keys.sv
// Keys and switches sitting on the shared port pins
`default_nettype none
module kil_keys (
  input  wire logic              aclk,   // Bus clock
  input  wire kil_pkg::kil_pad_t pad,    // Pad drive from the block
  input  wire logic [7:0]        press,  // Keys held down
  output logic [7:0]             level   // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt_q = 8'h55;  // Pattern on floating pins
  // Undriven pins wander every cycle
  always @(posedge aclk) begin
    flt_q <= ~flt_q;
  end
  // Key wins, then pad drive, then pull-up, else float
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = press[i] ? 1'b0 : pad.oe[i] ? pad.out[i] : pad.pull[i] ? 1'b1 : flt_q[i];
    end
  end
endmodule
`default_nettype wire

// ===== kil_top_assertions.sv
// Port-level assertions for the keypad interrupt latch
`default_nettype none
module kil_chk (
  input  wire logic              aclk,       // Bus clock
  input  wire logic              aresetn,    // Sync reset, active low
  input  wire logic              s_awvalid,  // Write address valid
  input  wire logic              s_wvalid,   // Write data valid
  input  wire logic              s_bvalid,   // Write response valid
  input  wire logic [7:0]        port_in,    // Pad levels
  input  wire kil_pkg::kil_pad_t port_pad,   // Pad drive
  input  wire logic              vec_fetch,  // CPU fetch strobe
  input  wire logic [15:0]       vec_addr,   // CPU fetch address
  input  wire logic              cpu_irq,    // CPU request
  input  wire logic              wake,       // Wake request
  input  wire logic              irq         // Status interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic quiet;  // No register write in flight
  assign quiet = !s_awvalid && !s_wvalid && !s_bvalid;
  // Some enabled pin low for five cycles
  sequence s_low5; (|(port_pad.pull & ~port_in))[*5]; endsequence
  // All enabled pins high for three cycles
  sequence s_high3; (&(port_in | ~port_pad.pull))[*3]; endsequence
  // Fetch of either handler vector byte
  sequence s_vec;
    vec_fetch && (vec_addr == kil_pkg::KIL_VEC_HI || vec_addr == kil_pkg::KIL_VEC_LO);
  endsequence
  AST_RESET: assert property (disable iff (1'b0) !aresetn |=>
    !cpu_irq && !irq && port_pad.pull == 8'h00) else $error("outputs not cleared by reset");
  AST_RELEASE: assert property ($rose(aresetn) |-> !cpu_irq ##1 !cpu_irq)
    else $error("request right after reset");
  AST_WAKE: assert property (wake == cpu_irq) else $error("wake differs from request");
  AST_PAD_IN: assert property ((port_pad.pull & port_pad.oe) == 8'h00)
    else $error("enabled pin still driven");
  AST_HOLD: assert property (s_low5 ##0 (cpu_irq && quiet) |=> cpu_irq)
    else $error("request dropped while pin low");
  AST_FETCH_HELD: assert property (
    s_low5 ##0 (cpu_irq && quiet) ##0 s_vec |=> cpu_irq[*2])
    else $error("fetch cleared a held request");
  AST_CLEAR: assert property (s_high3 ##0 s_vec ##0 quiet |-> ##[1:5] !cpu_irq)
    else $error("fetch did not clear request");
  AST_ISOLATE: assert property (
    (port_pad.pull == 8'h00 && quiet)[*5] ##0 !cpu_irq |=> !cpu_irq)
    else $error("request from disabled pins");
endmodule
bind kil_top kil_chk i_kil_chk (.aclk, .aresetn, .s_awvalid, .s_wvalid, .s_bvalid, .port_in,
  .port_pad, .vec_fetch, .vec_addr, .cpu_irq, .wake, .irq);
`default_nettype wire

// ===== kil_tb.sv
// Self-checking bench for the keypad interrupt latch
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0, vec_fetch = 0;
  logic s_bready = 1, s_rready = 1, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic cpu_irq, wake, irq, a0;
  logic [3:0] s_awaddr = 0, s_araddr = 0, s_wstrb = 4'h3;
  logic [31:0] s_wdata = 0, s_rdata, d;
  logic [1:0] s_bresp, s_rresp;
  logic [7:0] port_in, press = 0;
  logic [15:0] vec_addr = 0;
  kil_pkg::kil_pad_t port_pad;
  int err_total = 0, checks_done = 0;
  // Free-running bus clock
  always #2 aclk = ~aclk;
  kil_top i_kil_top (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .port_in, .port_pad, .vec_fetch, .vec_addr,
    .cpu_irq, .wake, .irq);
  kil_keys i_kil_keys (.aclk, .pad(port_pad), .press, .level(port_in));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Step one edge, giving up after a bound
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60) begin
      `CHK(n, 0)
      stop_test();
    end
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n = 0;
    logic aw = 0, w = 0;
    s_awaddr <= a; s_awvalid <= 1; s_wdata <= v; s_wvalid <= 1;
    while (!(aw && w)) begin
      step(n);
      if (!aw && s_awready === 1'b1) begin aw = 1; s_awvalid <= 0; end
      if (!w && s_wready === 1'b1) begin w = 1; s_wvalid <= 0; end
    end
    do step(n); while (s_bvalid !== 1'b1);
    `CHK(s_bresp, kil_pkg::KIL_RESP_OKAY)
    // One more edge so registered pad outputs show the write
    @(posedge aclk);
  endtask
  // Register read
  task automatic rd(input logic [3:0] a);
    int n = 0;
    s_araddr <= a; s_arvalid <= 1;
    do step(n); while (s_arready !== 1'b1);
    s_arvalid <= 0;
    do step(n); while (s_rvalid !== 1'b1);
    d = s_rdata;
    `CHK(s_rresp, kil_pkg::KIL_RESP_OKAY)
  endtask
  // Wait for the CPU request to reach a level
  task automatic wirq(input logic v);
    int n = 0;
    do step(n); while (cpu_irq !== v);
  endtask
  task automatic fetch(input logic [15:0] a);
    vec_addr <= a; vec_fetch <= 1;
    @(posedge aclk);
    vec_fetch <= 0;
  endtask
  task automatic do_reset();
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
  endtask
  task automatic t_reset();
    rd(kil_pkg::KIL_OFS_ENABLE);
    `CHK(d[7:0], kil_pkg::KIL_ENABLE_RST)
    rd(kil_pkg::KIL_OFS_ISC);
    `CHK(d[2:0], 3'h0)
    `CHK(cpu_irq, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_latch();
    wr(kil_pkg::KIL_OFS_PDIR, 32'hff);
    wr(kil_pkg::KIL_OFS_PDATA, 32'hff);
    wr(kil_pkg::KIL_OFS_ENABLE, 32'h01);
    `CHK(port_pad.pull, 8'h01)
    `CHK(port_pad.oe[0], 1'b0)
    `CHK(cpu_irq, 1'b0)
    press <= 8'h01;
    wirq(1);
    `CHK(wake, 1'b1)
    rd(kil_pkg::KIL_OFS_ISC);
    `CHK(d[0], 1'b1)
    fetch(kil_pkg::KIL_VEC_HI);
    repeat (8) @(posedge aclk);
    `CHK(cpu_irq, 1'b1)
    press <= 8'h00;
    wirq(0);
    $display("test latch done");
  endtask
  task automatic t_soft();
    wr(kil_pkg::KIL_OFS_ENABLE, 32'h03);
    press <= 8'h02;
    wirq(1);
    press <= 8'h00;
    repeat (8) @(posedge aclk);
    `CHK(cpu_irq, 1'b1)
    wr(kil_pkg::KIL_OFS_ISC, 32'h4);
    wirq(0);
    press <= 8'h01;
    wirq(1);
    press <= 8'h00;
    repeat (4) @(posedge aclk);
    fetch(kil_pkg::KIL_VEC_LO);
    wirq(0);
    $display("test soft done");
  endtask
  task automatic t_event();
    rd(kil_pkg::KIL_OFS_ENABLE);
    `CHK(d[8], 1'b1)
    wr(kil_pkg::KIL_OFS_ISC, 32'h000);
    @(posedge aclk);
    a0 = irq;
    wr(kil_pkg::KIL_OFS_ISC, 32'h100);
    @(posedge aclk);
    `CHK(a0, 1'b0)
    `CHK(irq, 1'b1)
    wr(kil_pkg::KIL_OFS_ENABLE, 32'h103);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(kil_pkg::KIL_OFS_ENABLE);
    `CHK(d[8], 1'b0)
    $display("test event done");
  endtask
  task automatic t_mask();
    wr(kil_pkg::KIL_OFS_ISC, 32'h2);
    wr(kil_pkg::KIL_OFS_ENABLE, 32'h0f);
    press <= 8'h02;
    repeat (10) @(posedge aclk);
    `CHK(cpu_irq, 1'b0)
    rd(kil_pkg::KIL_OFS_ISC);
    `CHK(d[1:0], 2'h3)
    wr(kil_pkg::KIL_OFS_PDIR, 32'hf0);
    wr(kil_pkg::KIL_OFS_PDATA, 32'hf5);
    `CHK(port_pad.oe, 8'hf0)
    `CHK(port_pad.out, 8'hf5)
    rd(kil_pkg::KIL_OFS_PDATA);
    `CHK(d[7:0], 8'hfd)
    wr(kil_pkg::KIL_OFS_ENABLE, 32'hff);
    `CHK(port_pad.oe, 8'h00)
    press <= 8'h00;
    wr(kil_pkg::KIL_OFS_ISC, 32'h6);
    wr(kil_pkg::KIL_OFS_ISC, 32'h0);
    repeat (4) @(posedge aclk);
    `CHK(cpu_irq, 1'b0)
    $display("test mask done");
  endtask
  initial begin
    do_reset();
    t_reset();
    t_latch();
    t_soft();
    t_event();
    t_mask();
    press <= 8'h80;
    repeat (6) @(posedge aclk);
    `CHK(cpu_irq, 1'b1)
    do_reset();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
